/* File: core/dtc_top.sv */
// Purpose: two timer/counters with run, gate, mode and external interrupt flags
// Assumes: pins synchronous to clk_i; single-cycle register write and read strobes
// Notes: power-down freezing is done by holding clk_i, idle leaves it running
`timescale 1ns/1ps
module dtc_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_bit_wr_i,
    input wire logic [2:0] reg_bit_sel_i,
    input wire logic reg_rd_i,
    input wire logic vector_timer_a_i,
    input wire logic vector_timer_b_i,
    input wire logic vector_ext_a_i,
    input wire logic vector_ext_b_i,
    input wire logic count_pin_a_i,
    input wire logic count_pin_b_i,
    input wire logic ext_int_pin_a_n_i,
    input wire logic ext_int_pin_b_n_i,
    input wire logic sleep_cpu_request_i,
    output logic [7:0] reg_rdata_o,
    output logic overflow_flag_a_o,
    output logic overflow_flag_b_o,
    output logic ext_irq_flag_a_o,
    output logic ext_irq_flag_b_o
);
    logic [7:0] timer_run_and_flag_control;
    logic [7:0] timer_mode_setup;
    logic [7:0] clock_divider_control;
    logic [7:0] lower_count_byte_a;
    logic [7:0] upper_count_byte_a;
    logic [7:0] lower_count_byte_b;
    logic [7:0] upper_count_byte_b;
    logic [3:0] div_cnt_a;
    logic [3:0] div_cnt_b;
    logic tick_a;
    logic tick_b;
    logic [1:0] sync_cnt_a;
    logic [1:0] sync_cnt_b;
    logic [1:0] sync_int_a;
    logic [1:0] sync_int_b;
    logic prev_cnt_a;
    logic prev_cnt_b;
    logic prev_int_a;
    logic prev_int_b;
    logic step_a;
    logic step_b;
    logic step_th_a;
    logic ovf_a;
    logic ovf_b;
    logic ovf_th_a;
    logic set_ie_a;
    logic set_ie_b;
    logic [7:0] next_control;
    logic [7:0] next_lo_a;
    logic [7:0] next_hi_a;
    logic [7:0] next_lo_b;
    logic [7:0] next_hi_b;
    logic [7:0] next_rdata;
    logic [7:0] wr_merge;
    dtc_pkg::dtc_mode_e mode_a;
    dtc_pkg::dtc_mode_e mode_b;

    // idle keeps this block clocked, so sleep_cpu_request_i changes nothing here
    wire unused_idle = sleep_cpu_request_i;

    assign mode_a = dtc_pkg::dtc_mode_e'(timer_mode_setup[dtc_pkg::BIT_MODE_HIGH:dtc_pkg::BIT_MODE_LOW]);
    assign mode_b = dtc_pkg::dtc_mode_e'(timer_mode_setup[dtc_pkg::MODE_NIBBLE_B + dtc_pkg::BIT_MODE_HIGH:
        dtc_pkg::MODE_NIBBLE_B + dtc_pkg::BIT_MODE_LOW]);

    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_cnt_a <= 2'h3;
            sync_cnt_b <= 2'h3;
            sync_int_a <= 2'h3;
            sync_int_b <= 2'h3;
        end else begin
            sync_cnt_a <= {sync_cnt_a[0], count_pin_a_i};
            sync_cnt_b <= {sync_cnt_b[0], count_pin_b_i};
            sync_int_a <= {sync_int_a[0], ext_int_pin_a_n_i};
            sync_int_b <= {sync_int_b[0], ext_int_pin_b_n_i};
        end
    end

    // previous synchronised levels for falling edge detection
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_cnt_a <= 1'b1;
            prev_cnt_b <= 1'b1;
            prev_int_a <= 1'b1;
            prev_int_b <= 1'b1;
        end else begin
            prev_cnt_a <= sync_cnt_a[1];
            prev_cnt_b <= sync_cnt_b[1];
            prev_int_a <= sync_int_a[1];
            prev_int_b <= sync_int_b[1];
        end
    end

    // internal tick dividers, one per timer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_cnt_a <= 4'h0;
            div_cnt_b <= 4'h0;
        end else begin
            div_cnt_a <= tick_a ? 4'h0 : div_cnt_a + 4'h1;
            div_cnt_b <= tick_b ? 4'h0 : div_cnt_b + 4'h1;
        end
    end

    // a divider change takes effect at once; >= ticks at once instead of wrapping through 15 after 12 -> 4
    assign tick_a = div_cnt_a >= (clock_divider_control[dtc_pkg::BIT_TIMER_A_CLOCK_DIVIDE_SELECT] ?
        dtc_pkg::DIVIDE_FAST_LAST : dtc_pkg::DIVIDE_SLOW_LAST);
    assign tick_b = div_cnt_b >= (clock_divider_control[dtc_pkg::BIT_TIMER_B_CLOCK_DIVIDE_SELECT] ?
        dtc_pkg::DIVIDE_FAST_LAST : dtc_pkg::DIVIDE_SLOW_LAST);

    // count enables: source select, run bit and optional gate on the interrupt pin
    always_comb begin
        step_a = (timer_mode_setup[dtc_pkg::BIT_COUNT_SOURCE] ? (prev_cnt_a & ~sync_cnt_a[1]) : tick_a)
            & timer_run_and_flag_control[dtc_pkg::BIT_RUN_CONTROL_A]
            & (~timer_mode_setup[dtc_pkg::BIT_GATE] | sync_int_a[1]);
        step_b = (timer_mode_setup[dtc_pkg::MODE_NIBBLE_B + dtc_pkg::BIT_COUNT_SOURCE] ?
            (prev_cnt_b & ~sync_cnt_b[1]) : tick_b)
            & timer_run_and_flag_control[dtc_pkg::BIT_RUN_CONTROL_B]
            & (~timer_mode_setup[dtc_pkg::MODE_NIBBLE_B + dtc_pkg::BIT_GATE] | sync_int_b[1]);
        // split upper byte of timer a: internal ticks only, timer b's run bit
        step_th_a = tick_a & timer_run_and_flag_control[dtc_pkg::BIT_RUN_CONTROL_B];
    end

    // timer a next count and overflow
    always_comb begin
        next_lo_a = lower_count_byte_a;
        next_hi_a = upper_count_byte_a;
        ovf_a = 1'b0;
        ovf_th_a = 1'b0;
        case (mode_a)
            dtc_pkg::DTC_MODE_13BIT: begin
                if (step_a) begin
                    next_lo_a = {3'h0, lower_count_byte_a[4:0] + 5'h01};
                    if (lower_count_byte_a[4:0] == dtc_pkg::PRESCALE_LAST) begin
                        next_hi_a = upper_count_byte_a + 8'h01;
                        ovf_a = upper_count_byte_a == 8'hFF;
                    end
                end
            end
            dtc_pkg::DTC_MODE_16BIT: begin
                if (step_a) begin
                    {next_hi_a, next_lo_a} = {upper_count_byte_a, lower_count_byte_a} + 16'h0001;
                    ovf_a = {upper_count_byte_a, lower_count_byte_a} == 16'hFFFF;
                end
            end
            dtc_pkg::DTC_MODE_RELOAD: begin
                if (step_a) begin
                    ovf_a = lower_count_byte_a == 8'hFF;
                    next_lo_a = ovf_a ? upper_count_byte_a : lower_count_byte_a + 8'h01;
                end
            end
            dtc_pkg::DTC_MODE_SPLIT: begin
                if (step_a) begin
                    next_lo_a = lower_count_byte_a + 8'h01;
                    ovf_a = lower_count_byte_a == 8'hFF;
                end
                if (step_th_a) begin
                    next_hi_a = upper_count_byte_a + 8'h01;
                    ovf_th_a = upper_count_byte_a == 8'hFF;
                end
            end
            default: begin
                next_lo_a = lower_count_byte_a;
            end
        endcase
    end

    // timer b next count and overflow; split mode holds it
    always_comb begin
        next_lo_b = lower_count_byte_b;
        next_hi_b = upper_count_byte_b;
        ovf_b = 1'b0;
        case (mode_b)
            dtc_pkg::DTC_MODE_13BIT: begin
                if (step_b) begin
                    next_lo_b = {3'h0, lower_count_byte_b[4:0] + 5'h01};
                    if (lower_count_byte_b[4:0] == dtc_pkg::PRESCALE_LAST) begin
                        next_hi_b = upper_count_byte_b + 8'h01;
                        ovf_b = upper_count_byte_b == 8'hFF;
                    end
                end
            end
            dtc_pkg::DTC_MODE_16BIT: begin
                if (step_b) begin
                    {next_hi_b, next_lo_b} = {upper_count_byte_b, lower_count_byte_b} + 16'h0001;
                    ovf_b = {upper_count_byte_b, lower_count_byte_b} == 16'hFFFF;
                end
            end
            dtc_pkg::DTC_MODE_RELOAD: begin
                if (step_b) begin
                    ovf_b = lower_count_byte_b == 8'hFF;
                    next_lo_b = ovf_b ? upper_count_byte_b : lower_count_byte_b + 8'h01;
                end
            end
            dtc_pkg::DTC_MODE_SPLIT: begin
                next_lo_b = lower_count_byte_b;
            end
            default: begin
                next_lo_b = lower_count_byte_b;
            end
        endcase
    end

    // external interrupt set conditions: falling edge when type is 1, low level when 0
    assign set_ie_a = timer_run_and_flag_control[dtc_pkg::BIT_EXT_IRQ_TYPE_A] ?
        (prev_int_a & ~sync_int_a[1]) : ~sync_int_a[1];
    assign set_ie_b = timer_run_and_flag_control[dtc_pkg::BIT_EXT_IRQ_TYPE_B] ?
        (prev_int_b & ~sync_int_b[1]) : ~sync_int_b[1];

    // single-bit writes touch only the selected bit
    always_comb begin
        wr_merge = timer_run_and_flag_control;
        if (reg_bit_wr_i) begin
            wr_merge[reg_bit_sel_i] = reg_wdata_i[0];
        end else begin
            wr_merge = reg_wdata_i;
        end
    end

    // control register: software write, then vector clears, then hardware sets win
    always_comb begin
        next_control = timer_run_and_flag_control;
        if ((reg_wr_i | reg_bit_wr_i) && reg_addr_i == dtc_pkg::ADDR_TIMER_RUN_AND_FLAG_CONTROL) begin
            next_control = wr_merge;
        end
        if (vector_timer_a_i) begin
            next_control[dtc_pkg::BIT_OVERFLOW_FLAG_A] = 1'b0;
        end
        if (vector_timer_b_i) begin
            next_control[dtc_pkg::BIT_OVERFLOW_FLAG_B] = 1'b0;
        end
        if (vector_ext_a_i && timer_run_and_flag_control[dtc_pkg::BIT_EXT_IRQ_TYPE_A]) begin
            next_control[dtc_pkg::BIT_EXT_IRQ_FLAG_A] = 1'b0;
        end
        if (vector_ext_b_i && timer_run_and_flag_control[dtc_pkg::BIT_EXT_IRQ_TYPE_B]) begin
            next_control[dtc_pkg::BIT_EXT_IRQ_FLAG_B] = 1'b0;
        end
        if (!timer_run_and_flag_control[dtc_pkg::BIT_EXT_IRQ_TYPE_A]) begin
            next_control[dtc_pkg::BIT_EXT_IRQ_FLAG_A] = set_ie_a;
        end else if (set_ie_a) begin
            next_control[dtc_pkg::BIT_EXT_IRQ_FLAG_A] = 1'b1;
        end
        if (!timer_run_and_flag_control[dtc_pkg::BIT_EXT_IRQ_TYPE_B]) begin
            next_control[dtc_pkg::BIT_EXT_IRQ_FLAG_B] = set_ie_b;
        end else if (set_ie_b) begin
            next_control[dtc_pkg::BIT_EXT_IRQ_FLAG_B] = 1'b1;
        end
        if (ovf_a) begin
            next_control[dtc_pkg::BIT_OVERFLOW_FLAG_A] = 1'b1;
        end
        if (ovf_b | ovf_th_a) begin
            next_control[dtc_pkg::BIT_OVERFLOW_FLAG_B] = 1'b1;
        end
    end

    // control register state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_run_and_flag_control <= dtc_pkg::RESET_CONTROL;
        end else begin
            timer_run_and_flag_control <= next_control;
        end
    end

    // mode and divider registers, byte writes only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_mode_setup <= dtc_pkg::RESET_MODE;
            clock_divider_control <= dtc_pkg::RESET_DIVIDER;
        end else if (reg_wr_i) begin
            if (reg_addr_i == dtc_pkg::ADDR_TIMER_MODE_SETUP) begin
                timer_mode_setup <= reg_wdata_i;
            end
            if (reg_addr_i == dtc_pkg::ADDR_CLOCK_DIVIDER_CONTROL) begin
                clock_divider_control <= reg_wdata_i;
            end
        end
    end

    // count registers; a software write to a byte overrides counting that cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lower_count_byte_a <= dtc_pkg::RESET_COUNT;
            upper_count_byte_a <= dtc_pkg::RESET_COUNT;
            lower_count_byte_b <= dtc_pkg::RESET_COUNT;
            upper_count_byte_b <= dtc_pkg::RESET_COUNT;
        end else begin
            lower_count_byte_a <= (reg_wr_i && reg_addr_i == dtc_pkg::ADDR_LOWER_COUNT_BYTE_A) ? reg_wdata_i : next_lo_a;
            upper_count_byte_a <= (reg_wr_i && reg_addr_i == dtc_pkg::ADDR_UPPER_COUNT_BYTE_A) ? reg_wdata_i : next_hi_a;
            lower_count_byte_b <= (reg_wr_i && reg_addr_i == dtc_pkg::ADDR_LOWER_COUNT_BYTE_B) ? reg_wdata_i : next_lo_b;
            upper_count_byte_b <= (reg_wr_i && reg_addr_i == dtc_pkg::ADDR_UPPER_COUNT_BYTE_B) ? reg_wdata_i : next_hi_b;
        end
    end

    // read mux; the divider's bits beyond the two select bits read back as ones
    always_comb begin
        case (reg_addr_i)
            dtc_pkg::ADDR_TIMER_RUN_AND_FLAG_CONTROL: next_rdata = timer_run_and_flag_control;
            dtc_pkg::ADDR_TIMER_MODE_SETUP: next_rdata = timer_mode_setup;
            dtc_pkg::ADDR_LOWER_COUNT_BYTE_A: next_rdata = lower_count_byte_a;
            dtc_pkg::ADDR_LOWER_COUNT_BYTE_B: next_rdata = lower_count_byte_b;
            dtc_pkg::ADDR_UPPER_COUNT_BYTE_A: next_rdata = upper_count_byte_a;
            dtc_pkg::ADDR_UPPER_COUNT_BYTE_B: next_rdata = upper_count_byte_b;
            dtc_pkg::ADDR_CLOCK_DIVIDER_CONTROL: next_rdata = clock_divider_control | 8'hE7;
            default: next_rdata = dtc_pkg::UNMAPPED_READ;
        endcase
    end

    // registered read data and flag outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= dtc_pkg::UNMAPPED_READ;
            overflow_flag_a_o <= 1'b0;
            overflow_flag_b_o <= 1'b0;
            ext_irq_flag_a_o <= 1'b0;
            ext_irq_flag_b_o <= 1'b0;
        end else begin
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
            overflow_flag_a_o <= next_control[dtc_pkg::BIT_OVERFLOW_FLAG_A];
            overflow_flag_b_o <= next_control[dtc_pkg::BIT_OVERFLOW_FLAG_B];
            ext_irq_flag_a_o <= next_control[dtc_pkg::BIT_EXT_IRQ_FLAG_A];
            ext_irq_flag_b_o <= next_control[dtc_pkg::BIT_EXT_IRQ_FLAG_B];
        end
    end

    // power-down: clk_i is stopped upstream, every register here simply holds
endmodule

/* File: inc/dtc_pkg.sv */
// Purpose: constants shared by the dual timer/counter block
// Assumes: 8-bit special-function-register access port, 200 MHz system clock
// Notes: counts, offsets and field positions are named here once
package dtc_pkg;
    // register addresses
    localparam logic [7:0] ADDR_TIMER_RUN_AND_FLAG_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE_SETUP = 8'h89;
    localparam logic [7:0] ADDR_LOWER_COUNT_BYTE_A = 8'h8A;
    localparam logic [7:0] ADDR_LOWER_COUNT_BYTE_B = 8'h8B;
    localparam logic [7:0] ADDR_UPPER_COUNT_BYTE_A = 8'h8C;
    localparam logic [7:0] ADDR_UPPER_COUNT_BYTE_B = 8'h8D;
    localparam logic [7:0] ADDR_CLOCK_DIVIDER_CONTROL = 8'h8E;
    // control register bit positions
    localparam int BIT_OVERFLOW_FLAG_B = 7;
    localparam int BIT_RUN_CONTROL_B = 6;
    localparam int BIT_OVERFLOW_FLAG_A = 5;
    localparam int BIT_RUN_CONTROL_A = 4;
    localparam int BIT_EXT_IRQ_FLAG_B = 3;
    localparam int BIT_EXT_IRQ_TYPE_B = 2;
    localparam int BIT_EXT_IRQ_FLAG_A = 1;
    localparam int BIT_EXT_IRQ_TYPE_A = 0;
    // mode register: timer a in low nibble, timer b in high nibble
    localparam int MODE_NIBBLE_B = 4;
    localparam int BIT_GATE = 3;
    localparam int BIT_COUNT_SOURCE = 2;
    localparam int BIT_MODE_HIGH = 1;
    localparam int BIT_MODE_LOW = 0;
    // clock divider control bit positions
    localparam int BIT_TIMER_A_CLOCK_DIVIDE_SELECT = 3;
    localparam int BIT_TIMER_B_CLOCK_DIVIDE_SELECT = 4;
    // reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_MODE = 8'h00;
    localparam logic [7:0] RESET_COUNT = 8'h00;
    localparam logic [7:0] RESET_DIVIDER = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;
    // tick dividers in system clocks
    localparam int DIVIDE_FAST = 4;
    localparam int DIVIDE_SLOW = 12;
    localparam logic [3:0] DIVIDE_FAST_LAST = 4'(DIVIDE_FAST - 1);
    localparam logic [3:0] DIVIDE_SLOW_LAST = 4'(DIVIDE_SLOW - 1);
    localparam logic [4:0] PRESCALE_LAST = 5'h1F;
    // counting modes
    typedef enum logic [1:0] {
        DTC_MODE_13BIT,
        DTC_MODE_16BIT,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_e;
endpackage

/* File: testbench/dtc_top_props.sv */
// Purpose: port-level checks of the dual timer/counter
// Assumes: one clock, synchronous active-low reset
// Notes: vector and ext-flag checks skip cycles with a register write
`timescale 1ns/1ps
module dtc_top_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_bit_wr_i,
    input wire logic [2:0] reg_bit_sel_i,
    input wire logic reg_rd_i,
    input wire logic vector_timer_a_i,
    input wire logic vector_timer_b_i,
    input wire logic ext_int_pin_a_n_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic overflow_flag_a_o,
    input wire logic overflow_flag_b_o,
    input wire logic ext_irq_flag_a_o,
    input wire logic ext_irq_flag_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic quiet;
    // no register write, so only hardware moves the flags
    assign quiet = !reg_wr_i && !reg_bit_wr_i;
    a_unmapped_reads_ones: assert property (reg_rd_i && (reg_addr_i < 8'h88 || reg_addr_i > 8'h8E)
        |=> reg_rdata_o == 8'hFF) else $error("hole in map did not read ones");
    a_reset_clears_all: assert property (disable iff (1'b0) !rst_n_i |=> reg_rdata_o == 8'hFF
        && !overflow_flag_a_o && !overflow_flag_b_o && !ext_irq_flag_a_o && !ext_irq_flag_b_o)
        else $error("reset left state behind");
    a_ctrl_read_mirror: assert property (reg_rd_i && reg_addr_i == 8'h88 |=>
        {reg_rdata_o[7], reg_rdata_o[5], reg_rdata_o[3], reg_rdata_o[1]} ==
        $past({overflow_flag_b_o, overflow_flag_a_o, ext_irq_flag_b_o, ext_irq_flag_a_o}))
        else $error("control read disagrees with flags");
    a_bit_set_ovf: assert property (reg_bit_wr_i && reg_addr_i == 8'h88 && reg_bit_sel_i == 3'h5
        && reg_wdata_i[0] |=> overflow_flag_a_o) else $error("bit write did not set flag a");
    a_byte_set_ovf: assert property (reg_wr_i && reg_addr_i == 8'h88 && reg_wdata_i[7]
        |=> overflow_flag_b_o) else $error("byte write did not set flag b");
    // overflow ticks are never on two neighbouring edges, so two vector cycles must leave a zero
    a_vector_clears_a: assert property ((vector_timer_a_i && quiet) [*2]
        |=> !(overflow_flag_a_o && $past(overflow_flag_a_o))) else $error("vector left flag a set");
    a_vector_clears_b: assert property ((vector_timer_b_i && quiet) [*2]
        |=> !(overflow_flag_b_o && $past(overflow_flag_b_o))) else $error("vector left flag b set");
    a_ext_rise_cause: assert property ($rose(ext_irq_flag_a_o) && $past(quiet) |->
        !$past(ext_int_pin_a_n_i, 2) || !$past(ext_int_pin_a_n_i, 3) || !$past(ext_int_pin_a_n_i, 4))
        else $error("ext flag a rose with pin high");
    c_ovf_a: cover property ($rose(overflow_flag_a_o));
    c_ovf_b: cover property ($rose(overflow_flag_b_o));
    c_ext_b: cover property ($rose(ext_irq_flag_b_o));
endmodule
bind dtc_top dtc_top_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_bit_wr_i(reg_bit_wr_i), .reg_bit_sel_i(reg_bit_sel_i),
    .reg_rd_i(reg_rd_i), .vector_timer_a_i(vector_timer_a_i), .vector_timer_b_i(vector_timer_b_i),
    .ext_int_pin_a_n_i(ext_int_pin_a_n_i), .reg_rdata_o(reg_rdata_o), .overflow_flag_a_o(overflow_flag_a_o),
    .overflow_flag_b_o(overflow_flag_b_o), .ext_irq_flag_a_o(ext_irq_flag_a_o), .ext_irq_flag_b_o(ext_irq_flag_b_o));

/* File: testbench/dtc_pin_model.sv */
// Purpose: far-side pins: count pulses and external interrupt levels
// Assumes: the block samples every pin on clk_i
// Notes: pads carry pull-ups, so every pin rests high
`timescale 1ns/1ps
module dtc_pin_model (
    input wire logic clk_i,
    input wire logic burst_i,
    input wire logic [7:0] burst_len_i,
    input wire logic level_a_n_i,
    input wire logic level_b_n_i,
    output logic count_pin_o,
    output logic ext_int_pin_a_n_o,
    output logic ext_int_pin_b_n_o,
    output logic busy_o
);
    logic [7:0] left = 8'h00;
    logic [1:0] phase = 2'h0;
    assign busy_o = (left != 8'h00);
    initial begin
        count_pin_o = 1'b1;
        ext_int_pin_a_n_o = 1'b1;
        ext_int_pin_b_n_o = 1'b1;
    end
    // two cycles low, two high per pulse: slow enough for the two-stage sync
    always @(posedge clk_i) begin
        ext_int_pin_a_n_o <= level_a_n_i;
        ext_int_pin_b_n_o <= level_b_n_i;
        if (burst_i) begin
            left <= burst_len_i;
            phase <= 2'h0;
        end else if (busy_o) begin
            count_pin_o <= phase[1];
            phase <= phase + 2'h1;
            left <= (phase == 2'h3) ? left - 8'h01 : left;
        end
    end
endmodule

/* File: testbench/dual_timer_counter_ext_int_flags_test.sv */
// Purpose: self-checking bench for the dual timer/counter
// Assumes: 200 MHz clock, inputs driven by non-blocking assignment at rising edges
// Notes: tick counts allow one tick of divider phase slack
`timescale 1ns/1ps
module dual_timer_counter_ext_int_flags_test;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, blen = 8'h05;
    logic bus_wr = 1'b0, bus_bwr = 1'b0, bus_rd = 1'b0, sleep = 1'b0, burst = 1'b0, lva = 1'b1, lvb = 1'b1;
    logic [2:0] bsel = 3'h0;
    logic [3:0] vec = 4'h0; // timer a, timer b, ext a, ext b
    wire [3:0] flg; // same order as vec
    wire [7:0] rdata;
    wire cpin, pa_n, pb_n, pbusy;
    int n_mismatch = 0, n_compared = 0, cycles = 0;

    always #2.5 clk_i = ~clk_i;

    dtc_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(bus_wr),
        .reg_bit_wr_i(bus_bwr), .reg_bit_sel_i(bsel), .reg_rd_i(bus_rd), .vector_timer_a_i(vec[0]),
        .vector_timer_b_i(vec[1]), .vector_ext_a_i(vec[2]), .vector_ext_b_i(vec[3]), .count_pin_a_i(cpin),
        .count_pin_b_i(cpin), .ext_int_pin_a_n_i(pa_n), .ext_int_pin_b_n_i(pb_n), .sleep_cpu_request_i(sleep),
        .reg_rdata_o(rdata), .overflow_flag_a_o(flg[0]), .overflow_flag_b_o(flg[1]), .ext_irq_flag_a_o(flg[2]),
        .ext_irq_flag_b_o(flg[3]));
    dtc_pin_model u_pins (.clk_i(clk_i), .burst_i(burst), .burst_len_i(blen), .level_a_n_i(lva),
        .level_b_n_i(lvb), .count_pin_o(cpin), .ext_int_pin_a_n_o(pa_n), .ext_int_pin_b_n_o(pb_n), .busy_o(pbusy));

    // a hang counts as a mismatch and ends the run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_i);
        bus_wr <= 1'b0;
    endtask
    task automatic put_bit(input logic [2:0] s, input logic v);
        @(posedge clk_i);
        addr <= 8'h88;
        bsel <= s;
        wdata <= {7'h00, v};
        bus_bwr <= 1'b1;
        @(posedge clk_i);
        bus_bwr <= 1'b0;
    endtask
    task automatic get_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_i);
        bus_rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic expect_byte(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        get_byte(a, d);
        chk(d, e);
    endtask
    // waits a bounded number of edges for a flag level, then judges it
    task automatic wait_flag(input int k, input logic v, input int lim);
        #1;
        for (int i = 0; i < lim && flg[k] !== v; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk({7'h00, flg[k]}, {7'h00, v});
    endtask
    task automatic pulse_vec(input int k, input int n);
        @(posedge clk_i);
        vec[k] <= 1'b1;
        repeat (n) @(posedge clk_i);
        vec[k] <= 1'b0;
    endtask
    task automatic drive_pin(input int k, input logic v);
        @(posedge clk_i);
        {lvb, lva} <= (k == 1) ? {v, lva} : {lvb, v};
    endtask

    task automatic t_reset();
        for (int a = 8'h87; a <= 8'h8F; a++) begin
            expect_byte(8'(a), (a == 8'h8E) ? 8'hE7 : (a == 8'h87 || a == 8'h8F) ? 8'hFF : 8'h00);
        end
        put_byte(8'h8F, 8'h00);
        expect_byte(8'h8F, 8'hFF);
    endtask
    // one overflow each in 13-bit, 16-bit and reload modes, idle request held high throughout
    task automatic t_modes();
        logic [7:0] md [3] = '{8'h00, 8'h01, 8'h02};
        logic [7:0] lo [3] = '{8'h1F, 8'hFE, 8'hFE};
        logic [7:0] hi [3] = '{8'hFF, 8'hFF, 8'hF0};
        logic [7:0] elo [3] = '{8'h00, 8'h00, 8'hF0};
        @(posedge clk_i);
        sleep <= 1'b1;
        put_byte(8'h8E, 8'h08);
        for (int i = 0; i < 3; i++) begin
            put_byte(8'h89, md[i]);
            put_byte(8'h8A, lo[i]);
            put_byte(8'h8C, hi[i]);
            put_byte(8'h88, 8'h10);
            wait_flag(0, 1'b1, 40);
            put_bit(3'h4, 1'b0);
            expect_byte(8'h8A, elo[i]);
            expect_byte(8'h8C, elo[i]);
        end
        expect_byte(8'h88, 8'h20);
        pulse_vec(0, 2);
        wait_flag(0, 1'b0, 0);
        put_bit(3'h5, 1'b1);
        expect_byte(8'h88, 8'h20);
        put_byte(8'h88, 8'hA0);
        expect_byte(8'h88, 8'hA0);
    endtask
    // fifty running edges, then the count must stay put
    task automatic t_divide();
        logic [7:0] d;
        for (int f = 0; f < 2; f++) begin
            put_byte(8'h8E, f ? 8'h08 : 8'h00);
            put_byte(8'h89, 8'h01);
            put_byte(8'h8A, 8'h00);
            put_bit(3'h4, 1'b1);
            repeat (48) @(posedge clk_i);
            put_bit(3'h4, 1'b0);
            get_byte(8'h8A, d);
            chk({7'h00, d == 8'(50 / (f ? 4 : 12)) || d == 8'(50 / (f ? 4 : 12) + 1)}, 8'h01);
            repeat (30) @(posedge clk_i);
            expect_byte(8'h8A, d);
        end
    endtask
    task automatic t_split();
        put_byte(8'h89, 8'h33);
        put_byte(8'h8A, 8'h00);
        put_byte(8'h8B, 8'h05);
        put_byte(8'h8C, 8'hFE);
        put_byte(8'h88, 8'h40);
        wait_flag(1, 1'b1, 80);
        put_bit(3'h6, 1'b0);
        expect_byte(8'h8A, 8'h00);
        expect_byte(8'h8B, 8'h05);
        pulse_vec(1, 2);
        wait_flag(1, 1'b0, 0);
    endtask
    task automatic t_gate();
        logic [7:0] d, e;
        drive_pin(0, 1'b0);
        put_byte(8'h89, 8'h09);
        put_byte(8'h8A, 8'h00);
        put_byte(8'h88, 8'h10);
        repeat (40) @(posedge clk_i);
        expect_byte(8'h8A, 8'h00);
        drive_pin(0, 1'b1);
        repeat (40) @(posedge clk_i);
        get_byte(8'h8A, d);
        chk({7'h00, d != 8'h00}, 8'h01);
        drive_pin(0, 1'b0);
        put_byte(8'h89, 8'h01);
        get_byte(8'h8A, d);
        repeat (40) @(posedge clk_i);
        get_byte(8'h8A, e);
        chk({7'h00, e != d}, 8'h01);
        drive_pin(0, 1'b1);
    endtask
    task automatic t_count();
        put_byte(8'h89, 8'h55);
        put_byte(8'h8A, 8'h00);
        put_byte(8'h8B, 8'h00);
        put_byte(8'h88, 8'h50);
        burst <= 1'b1;
        @(posedge clk_i);
        burst <= 1'b0;
        for (int i = 0; i < 60 && (i == 0 || pbusy !== 1'b0); i++) begin
            @(posedge clk_i);
            #1;
        end
        repeat (4) @(posedge clk_i);
        expect_byte(8'h8A, 8'h05);
        expect_byte(8'h8B, 8'h05);
    endtask
    // falling edge then low level on each interrupt pin
    task automatic t_ext();
        for (int k = 0; k < 2; k++) begin
            put_bit(k ? 3'h2 : 3'h0, 1'b1);
            drive_pin(k, 1'b0);
            wait_flag(2 + k, 1'b1, 8);
            drive_pin(k, 1'b1);
            pulse_vec(2 + k, 1);
            wait_flag(2 + k, 1'b0, 0);
            put_bit(k ? 3'h2 : 3'h0, 1'b0);
            drive_pin(k, 1'b0);
            wait_flag(2 + k, 1'b1, 8);
            pulse_vec(2 + k, 1);
            wait_flag(2 + k, 1'b1, 0);
            drive_pin(k, 1'b1);
            wait_flag(2 + k, 1'b0, 8);
        end
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_modes();
        t_divide();
        t_split();
        t_gate();
        t_count();
        t_ext();
        close_out();
    end
endmodule
